// [hw/ufc_defs.vh]
// Purpose: constants of the uart fifo/interrupt/line control block
// Assumes: included by hw/ufc_ctrl.v only
// Notes: offsets are the three-bit register addresses
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH
// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define UFC_A_DATA 3'h0
`define UFC_A_IER 3'h1
`define UFC_A_IIR 3'h2
`define UFC_A_LCR 3'h3
`define UFC_A_LSR 3'h5
`define UFC_A_MSR 3'h6
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UFC_IER_EXT 5
`define UFC_FCR_EN 0
`define UFC_FCR_RXCLR 1
`define UFC_FCR_TXCLR 2
`define UFC_FCR_DMA 3
`define UFC_LCR_STB 2
`define UFC_LCR_PEN 3
`define UFC_LCR_EPS 4
`define UFC_LCR_STICK 5
`define UFC_LCR_BRK 6
`define UFC_LCR_DLAB 7
// ------------------------------------------------------------
// reset values and identification codes
// ------------------------------------------------------------
`define UFC_RST_REG 8'h00
`define UFC_ID_NONE 4'h1
`define UFC_ID_RLS 4'h6
`define UFC_ID_RDA 4'h4
`define UFC_ID_TO 4'hC
`define UFC_ID_TX_HOLDING_EMPTY 4'h2
`define UFC_ID_MS 4'h0
// ------------------------------------------------------------
// timing: character times without fifo traffic
// ------------------------------------------------------------
`define UFC_TO_CHARS 3'h4
`endif

// [hw/ufc_ctrl.v]
// Purpose: interrupt, fifo and line format control of a fifo uart
// Assumes: host strobes and shifter pulses are on ref_clk
// Notes: serial shifters, baud divisor, modem and line status live
//        outside; this block holds both character fifos
`timescale 1ns/1ps
`include "ufc_defs.vh"

// Operation
// - ier bits 0-3 enable the four interrupt groups
// - ier bit 5 enters extended mode
// - ier bits 4,6,7 read zero
// - ident read freezes top pending interrupt other than holding empty
// - ident bit 0 low when interrupt pending
// - ident bit 3 zero without fifo mode
// - ident bit 4 transmitter not full, extended only
// - ident bit 5 receiver not empty, extended only
// - ident bits 6,7 show fifo mode
// - ident codes and priority order fixed
// - each source cleared by its own read
// - holding empty cleared by ident read, write, trigger
// - timeout after four idle character times
// - fifo control bits ignored unless bit 0 set
// - fifo mode change clears both fifos
// - fifo reset bits empty fifo, self clear
// - fifo control bit 3 selects dma mode
// - transmit trigger 1,4,8,14 in extended mode
// - receive trigger 1,4,8,14 drives data available
// - line format register reads back
// - word length five to eight bits
// - one, one-and-half or two stop bits
// - parity bit generated and checked when enabled
// - parity odd, even, mark or space
// - ier bits 0-3 clear disables interrupts
// - reset clears control registers, ident reads 01
module ufc_ctrl #(
    parameter DEPTH = 16,
    parameter PW = 4
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // host register port
    input wire bus_sel,
    input wire [2:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    output reg [7:0] bus_rdata_q,
    // receive shifter side
    input wire rx_push,
    input wire [7:0] rx_data,
    input wire rx_par_in,
    input wire rx_stop_in,
    input wire rx_break,
    input wire char_tick,
    // transmit shifter side
    input wire tx_take,
    output reg [7:0] tx_data_q,
    output reg tx_avail_q,
    output reg tx_par_q,
    // line format to shifters
    output reg [1:0] word_len_q,
    output reg stop_half_q,
    output reg stop_two_q,
    output reg parity_on_q,
    output reg break_q,
    output reg dlab_q,
    // modem side
    input wire modem_chg,
    input wire osc_off_bit,
    output reg osc_stop_q,
    // interrupt and dma pins
    output reg irq_q,
    output reg tx_dma_request_n_q,
    output reg rx_dma_request_n_q
);

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [4:0] ier_q;
reg [7:0] lcr_q;
reg fen_q;
reg dma_q;
reg [1:0] txtrg_q;
reg [1:0] rxtrg_q;
reg rls_q;
reg ms_q;
reg tx_holding_empty_q;
reg below_q;
reg to_q;
reg [2:0] to_cnt_q;
reg frz_q;
reg [3:0] frz_id_q;
reg [7:0] rx_mem [0:DEPTH-1];
reg [7:0] tx_mem [0:DEPTH-1];
reg [PW-1:0] rx_wp_q;
reg [PW-1:0] rx_rp_q;
reg [PW:0] rx_cnt_q;
reg [PW-1:0] tx_wp_q;
reg [PW-1:0] tx_rp_q;
reg [PW:0] tx_cnt_q;

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
function [4:0] trig_lvl;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: trig_lvl = 5'h01;
            2'h1: trig_lvl = 5'h04;
            2'h2: trig_lvl = 5'h08;
            default: trig_lvl = 5'h0E;
        endcase
    end
endfunction

function [7:0] len_mask;
    input [1:0] wl;
    begin
        case (wl)
            2'h0: len_mask = 8'h1F;
            2'h1: len_mask = 8'h3F;
            2'h2: len_mask = 8'h7F;
            default: len_mask = 8'hFF;
        endcase
    end
endfunction

// parity of masked data for the current format
function par_of;
    input [7:0] d;
    input [7:0] line_format_control;
    begin
        if (line_format_control[`UFC_LCR_STICK]) begin
            par_of = ~line_format_control[`UFC_LCR_EPS];
        end else if (line_format_control[`UFC_LCR_EPS]) begin
            par_of = ^d;
        end else begin
            par_of = ~(^d);
        end
    end
endfunction

// ------------------------------------------------------------
// decode
// ------------------------------------------------------------
wire dlab = lcr_q[`UFC_LCR_DLAB];
wire ext = ier_q[4];
wire wr_go = bus_sel & bus_wr;
wire rd_go = bus_sel & bus_rd;
wire thr_wr = wr_go & (bus_addr == `UFC_A_DATA) & ~dlab;
wire ier_wr = wr_go & (bus_addr == `UFC_A_IER) & ~dlab;
wire fcr_wr = wr_go & (bus_addr == `UFC_A_IIR);
wire lcr_wr = wr_go & (bus_addr == `UFC_A_LCR);
wire rbr_rd = rd_go & (bus_addr == `UFC_A_DATA) & ~dlab;
wire iir_rd = rd_go & (bus_addr == `UFC_A_IIR);
wire lsr_rd = rd_go & (bus_addr == `UFC_A_LSR);
wire msr_rd = rd_go & (bus_addr == `UFC_A_MSR);

// ------------------------------------------------------------
// fifo control
// ------------------------------------------------------------
wire fcr_on = bus_wdata[`UFC_FCR_EN];
wire fmode_chg = fcr_wr & (fcr_on != fen_q);
wire rx_clr = fmode_chg | (fcr_wr & fcr_on & bus_wdata[`UFC_FCR_RXCLR]);
wire tx_clr = fmode_chg | (fcr_wr & fcr_on & bus_wdata[`UFC_FCR_TXCLR]);
wire [PW:0] cap = fen_q ? DEPTH[PW:0] : {{PW{1'b0}}, 1'b1};
wire [4:0] rx_trig = fen_q ? trig_lvl(rxtrg_q) : 5'h01;
wire [4:0] tx_trig = (fen_q & ext) ? trig_lvl(txtrg_q) : 5'h01;
wire rx_full = (rx_cnt_q == cap);
wire tx_full = (tx_cnt_q == cap);
wire rx_nempty = (rx_cnt_q != {(PW+1){1'b0}});
wire rx_pop = rbr_rd & rx_nempty;
wire tx_pop = tx_take & (tx_cnt_q != {(PW+1){1'b0}});
wire rx_in = rx_push & ~rx_full;
wire tx_in = thr_wr & ~tx_full;
wire below = ({{(5-PW-1){1'b0}}, tx_cnt_q} < tx_trig);
wire rda = ({{(5-PW-1){1'b0}}, rx_cnt_q} >= rx_trig);

// received character checks
wire [7:0] rx_m = rx_data & len_mask(lcr_q[1:0]);
wire par_bad = lcr_q[`UFC_LCR_PEN] &
    (rx_par_in != par_of(rx_m, lcr_q));
wire rx_err = rx_push & (rx_full | par_bad | ~rx_stop_in | rx_break);

// ------------------------------------------------------------
// interrupt sources and identification
// ------------------------------------------------------------
wire p_rls = ier_q[2] & rls_q;
wire p_rda = ier_q[0] & rda;
wire p_to = ier_q[0] & to_q & fen_q;
wire p_tx_holding_empty = ier_q[1] & tx_holding_empty_q;
wire p_ms = ier_q[3] & ms_q;
wire pend = p_rls | p_rda | p_to | p_tx_holding_empty | p_ms;
reg [3:0] cur_id;
reg frz_live;

always @* begin
    if (p_rls) begin
        cur_id = `UFC_ID_RLS;
    end else if (p_rda) begin
        cur_id = `UFC_ID_RDA;
    end else if (p_to) begin
        cur_id = `UFC_ID_TO;
    end else if (p_tx_holding_empty) begin
        cur_id = `UFC_ID_TX_HOLDING_EMPTY;
    end else if (p_ms) begin
        cur_id = `UFC_ID_MS;
    end else begin
        cur_id = `UFC_ID_NONE;
    end
    case (frz_id_q)
        `UFC_ID_RLS: frz_live = p_rls;
        `UFC_ID_RDA: frz_live = p_rda;
        `UFC_ID_TO: frz_live = p_to;
        `UFC_ID_TX_HOLDING_EMPTY: frz_live = p_tx_holding_empty;
        `UFC_ID_MS: frz_live = p_ms;
        default: frz_live = 1'b0;
    endcase
end

wire frozen = frz_q & frz_live;
wire [3:0] rep_id = frozen ? frz_id_q : cur_id;
wire [7:0] iir_val = {fen_q, fen_q,
    ext & rx_nempty,
    ext & ~tx_full,
    rep_id[3] & fen_q,
    rep_id[2:1],
    ~(pend | frozen)};

// ------------------------------------------------------------
// control registers
// ------------------------------------------------------------
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        ier_q <= 5'h00;
        lcr_q <= `UFC_RST_REG;
        fen_q <= 1'b0;
        dma_q <= 1'b0;
        txtrg_q <= 2'h0;
        rxtrg_q <= 2'h0;
    end else begin
        if (ier_wr) begin
            ier_q <= {bus_wdata[`UFC_IER_EXT], bus_wdata[3:0]};
        end
        if (lcr_wr) begin
            lcr_q <= bus_wdata;
        end
        if (fcr_wr) begin
            fen_q <= fcr_on;
            if (fcr_on) begin
                dma_q <= bus_wdata[`UFC_FCR_DMA];
                txtrg_q <= bus_wdata[5:4];
                rxtrg_q <= bus_wdata[7:6];
            end
        end
    end
end

// ------------------------------------------------------------
// fifo storage and receive fifo pointers
// ------------------------------------------------------------
always @(posedge ref_clk) begin
    if (rx_in) begin
        rx_mem[rx_wp_q] <= rx_m;
    end
    if (tx_in) begin
        tx_mem[tx_wp_q] <= bus_wdata;
    end
end

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        rx_wp_q <= {PW{1'b0}};
        rx_rp_q <= {PW{1'b0}};
        rx_cnt_q <= {(PW+1){1'b0}};
    end else if (rx_clr) begin
        rx_wp_q <= {PW{1'b0}};
        rx_rp_q <= {PW{1'b0}};
        rx_cnt_q <= {(PW+1){1'b0}};
    end else begin
        if (rx_in) begin
            rx_wp_q <= rx_wp_q + {{(PW-1){1'b0}}, 1'b1};
        end
        if (rx_pop) begin
            rx_rp_q <= rx_rp_q + {{(PW-1){1'b0}}, 1'b1};
        end
        if (rx_in & ~rx_pop) begin
            rx_cnt_q <= rx_cnt_q + {{PW{1'b0}}, 1'b1};
        end else if (rx_pop & ~rx_in) begin
            rx_cnt_q <= rx_cnt_q - {{PW{1'b0}}, 1'b1};
        end
    end
end

// ------------------------------------------------------------
// transmit fifo
// ------------------------------------------------------------
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        tx_wp_q <= {PW{1'b0}};
        tx_rp_q <= {PW{1'b0}};
        tx_cnt_q <= {(PW+1){1'b0}};
    end else if (tx_clr) begin
        tx_wp_q <= {PW{1'b0}};
        tx_rp_q <= {PW{1'b0}};
        tx_cnt_q <= {(PW+1){1'b0}};
    end else begin
        if (tx_in) begin
            tx_wp_q <= tx_wp_q + {{(PW-1){1'b0}}, 1'b1};
        end
        if (tx_pop) begin
            tx_rp_q <= tx_rp_q + {{(PW-1){1'b0}}, 1'b1};
        end
        if (tx_in & ~tx_pop) begin
            tx_cnt_q <= tx_cnt_q + {{PW{1'b0}}, 1'b1};
        end else if (tx_pop & ~tx_in) begin
            tx_cnt_q <= tx_cnt_q - {{PW{1'b0}}, 1'b1};
        end
    end
end

// ------------------------------------------------------------
// interrupt flags, timeout and freeze
// ------------------------------------------------------------
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        rls_q <= 1'b0;
        ms_q <= 1'b0;
        tx_holding_empty_q <= 1'b0;
        below_q <= 1'b0;
        to_q <= 1'b0;
        to_cnt_q <= 3'h0;
        frz_q <= 1'b0;
        frz_id_q <= `UFC_ID_NONE;
    end else begin
        // set wins over the clearing read
        rls_q <= rx_err | (rls_q & ~lsr_rd);
        ms_q <= modem_chg | (ms_q & ~msr_rd);
        below_q <= below;
        if ((below & ~below_q) | (ier_wr & bus_wdata[1] & below)) begin
            tx_holding_empty_q <= 1'b1;
        end else if (thr_wr | ~below) begin
            tx_holding_empty_q <= 1'b0;
        end else if (iir_rd & (rep_id == `UFC_ID_TX_HOLDING_EMPTY)) begin
            tx_holding_empty_q <= 1'b0;
        end
        if (~fen_q | ~rx_nempty | rx_in | rx_pop) begin
            to_cnt_q <= 3'h0;
            to_q <= 1'b0;
        end else if (char_tick & (to_cnt_q != `UFC_TO_CHARS)) begin
            to_cnt_q <= to_cnt_q + 3'h1;
            to_q <= (to_cnt_q == (`UFC_TO_CHARS - 3'h1));
        end
        if (iir_rd & pend & (rep_id != `UFC_ID_TX_HOLDING_EMPTY)) begin
            frz_q <= 1'b1;
            frz_id_q <= rep_id;
        end else if (~frz_live) begin
            frz_q <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// read data and output pins
// ------------------------------------------------------------
reg [7:0] rd_mux;

always @* begin
    rd_mux = 8'h00;
    case (bus_addr)
        `UFC_A_DATA: rd_mux = dlab ? 8'h00 : rx_mem[rx_rp_q];
        `UFC_A_IER: rd_mux = dlab ? 8'h00 :
            {2'h0, ier_q[4], 1'b0, ier_q[3:0]};
        `UFC_A_IIR: rd_mux = iir_val;
        `UFC_A_LCR: rd_mux = lcr_q;
        default: rd_mux = 8'h00;
    endcase
end

wire [7:0] tx_head = tx_mem[tx_rp_q];

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        bus_rdata_q <= 8'h00;
        tx_data_q <= 8'h00;
        tx_avail_q <= 1'b0;
        tx_par_q <= 1'b0;
        word_len_q <= 2'h0;
        stop_half_q <= 1'b0;
        stop_two_q <= 1'b0;
        parity_on_q <= 1'b0;
        break_q <= 1'b0;
        dlab_q <= 1'b0;
        osc_stop_q <= 1'b0;
        irq_q <= 1'b0;
        tx_dma_request_n_q <= 1'b1;
        rx_dma_request_n_q <= 1'b1;
    end else begin
        if (rd_go) begin
            bus_rdata_q <= rd_mux;
        end
        tx_data_q <= tx_head & len_mask(lcr_q[1:0]);
        tx_avail_q <= (tx_cnt_q != {(PW+1){1'b0}});
        tx_par_q <= par_of(tx_head & len_mask(lcr_q[1:0]), lcr_q);
        word_len_q <= lcr_q[1:0];
        stop_half_q <= lcr_q[`UFC_LCR_STB] & (lcr_q[1:0] == 2'h0);
        stop_two_q <= lcr_q[`UFC_LCR_STB] & (lcr_q[1:0] != 2'h0);
        parity_on_q <= lcr_q[`UFC_LCR_PEN];
        break_q <= lcr_q[`UFC_LCR_BRK];
        dlab_q <= dlab;
        osc_stop_q <= ext & osc_off_bit;
        irq_q <= pend;
        if (dma_q & fen_q) begin
            tx_dma_request_n_q <= tx_full;
            rx_dma_request_n_q <= ~(rda | to_q);
        end else begin
            tx_dma_request_n_q <= tx_cnt_q != {(PW+1){1'b0}};
            rx_dma_request_n_q <= ~rx_nempty;
        end
    end
end

endmodule // ufc_ctrl

// [tb/ufc_ctrl_asserts.sv]
// Purpose: port-level checks of the fifo uart control block
// Assumes: registers are reached only through the host strobes
// Notes: small shadows of line format and interrupt enable
`timescale 1ns/1ps
module ufc_ctrl_chk #(
    parameter DEPTH = 16
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // host port
    input wire bus_sel,
    input wire [2:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    input wire [7:0] bus_rdata_q,
    // watched outputs
    input wire [7:0] tx_data_q,
    input wire tx_avail_q,
    input wire tx_par_q,
    input wire [1:0] word_len_q,
    input wire stop_half_q,
    input wire stop_two_q,
    input wire parity_on_q,
    input wire dlab_q,
    input wire osc_stop_q,
    input wire irq_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg [7:0] lf_q;
    reg [7:0] lf_p1_q;
    reg [7:0] lf_p2_q;
    reg [5:0] ie_q;
    wire rd_id = bus_sel && bus_rd && bus_addr == 3'h2;
    wire rd_ie = bus_sel && bus_rd && bus_addr == 3'h1 && !lf_q[7];
    wire wr_ie = bus_sel && bus_wr && bus_addr == 3'h1 && !lf_q[7];
    wire wr_lf = bus_sel && bus_wr && bus_addr == 3'h3;
    // ------------------------------------------------------------
    // shadows of host writes
    // ------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lf_q <= 8'h00;
            lf_p1_q <= 8'h00;
            lf_p2_q <= 8'h00;
            ie_q <= 6'h00;
        end else begin
            lf_p1_q <= lf_q;
            lf_p2_q <= lf_p1_q;
            if (wr_lf) lf_q <= bus_wdata;
            if (wr_ie) ie_q <= bus_wdata[5:0];
        end
    end
    wire lf_still = lf_p1_q == lf_q && lf_p2_q == lf_q;
    wire odd_p = ~^tx_data_q;
    wire par_exp = lf_q[5] ? ~lf_q[4] : (lf_q[4] ? ~odd_p : odd_p);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_ier_zero: assert property (
        rd_ie |=> bus_rdata_q[7:6] == 2'h0 && !bus_rdata_q[4])
        else $error("ier reserved bits not zero");
    chk_id_code: assert property (
        rd_id |=> bus_rdata_q[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0})
        else $error("ident code not legal");
    chk_id_fifo: assert property (
        rd_id |=> bus_rdata_q[7] == bus_rdata_q[6])
        else $error("ident fifo bits differ");
    chk_id_bit3: assert property (
        rd_id |=> bus_rdata_q[6] || !bus_rdata_q[3])
        else $error("ident bit 3 set without fifo mode");
    chk_id_pend: assert property (
        rd_id |=> bus_rdata_q[0] == (bus_rdata_q[3:0] == 4'h1))
        else $error("ident pending bit wrong");
    chk_fmt_load: assert property (
        wr_lf ##1 !wr_lf |-> ##1 word_len_q == $past(bus_wdata[1:0], 2)
        && parity_on_q == $past(bus_wdata[3], 2)
        && dlab_q == $past(bus_wdata[7], 2))
        else $error("line format outputs wrong");
    chk_stop_sel: assert property (
        lf_still |-> stop_half_q == (lf_q[2] && lf_q[1:0] == 2'h0)
        && stop_two_q == (lf_q[2] && lf_q[1:0] != 2'h0))
        else $error("stop bit selection wrong");
    chk_par_kind: assert property (
        tx_avail_q && parity_on_q && lf_still
        && $past(tx_data_q, 2) == tx_data_q |-> tx_par_q == par_exp)
        else $error("transmit parity wrong");
    chk_irq_off: assert property (
        ie_q[3:0] == 4'h0 && $past(ie_q[3:0]) == 4'h0
        && $past(ie_q[3:0], 2) == 4'h0 |-> !irq_q)
        else $error("interrupt with all enables off");
    chk_osc_ext: assert property (
        !ie_q[5] && !$past(ie_q[5]) |-> !osc_stop_q)
        else $error("oscillator stop outside extended mode");
endmodule // ufc_ctrl_chk

bind ufc_ctrl ufc_ctrl_chk #(.DEPTH(DEPTH)) i_ufc_ctrl_chk (
    .ref_clk, .rst, .bus_sel, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata_q, .tx_data_q, .tx_avail_q, .tx_par_q, .word_len_q,
    .stop_half_q, .stop_two_q, .parity_on_q, .dlab_q, .osc_stop_q, .irq_q
);

// [tb/ufc_shift_model.sv]
// Purpose: transmit shifter and character timer beside the block
// Assumes: one character taken at a time
// Notes: take delay varies so the block sees prompt and slow takes
`timescale 1ns/1ps
module ufc_shift_model (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // transmit side
    input wire tx_avail_q,
    input wire [7:0] tx_data_q,
    output reg tx_take,
    output reg [7:0] last_byte_q,
    output reg [7:0] n_taken_q,
    // character timing
    input wire tick_en,
    output reg char_tick
);
    reg [3:0] wait_q;
    reg [2:0] tick_q;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_take <= 1'b0;
            last_byte_q <= 8'h00;
            n_taken_q <= 8'h00;
            char_tick <= 1'b0;
            wait_q <= 4'h0;
            tick_q <= 3'h0;
        end else begin
            tx_take <= 1'b0;
            tick_q <= tick_q + 3'h1;
            char_tick <= tick_en && tick_q == 3'h7;
            if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (tx_avail_q) begin
                // take the head byte at once, then hold off for 4 to 7 cycles
                tx_take <= 1'b1;
                last_byte_q <= tx_data_q;
                n_taken_q <= n_taken_q + 8'h01;
                wait_q <= {2'h1, n_taken_q[1:0]};
            end
        end
    end
endmodule // ufc_shift_model

// [tb/ufc_ctrl_bench.sv]
// Purpose: self-checking bench of the fifo uart control block
// Assumes: parity and break inputs idle, oscillator-off bit high
// Notes: lfsr stimulus from a fixed seed
`timescale 1ns/1ps
module ufc_ctrl_bench;
    reg ref_clk, rst, bus_sel, bus_wr, bus_rd, rx_push, rx_stop_in;
    reg modem_chg, tick_en;
    reg [2:0] bus_addr;
    reg [7:0] bus_wdata, rx_data, b, rd_v;
    reg [7:0] q [0:3];
    reg [31:0] seed;
    wire [7:0] bus_rdata_q, tx_data_q, last_byte_q, n_taken_q;
    wire [1:0] word_len_q;
    wire tx_avail_q, tx_par_q, stop_half_q, stop_two_q, parity_on_q;
    wire break_q, dlab_q, osc_stop_q, irq_q, tx_take, char_tick;
    wire tx_dma_request_n_q, rx_dma_request_n_q;
    integer failures, n_compared, i, c;
    ufc_ctrl i_ufc_ctrl (
        .ref_clk(ref_clk), .rst(rst), .bus_sel(bus_sel),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
        .rx_push(rx_push), .rx_data(rx_data), .rx_par_in(1'b0),
        .rx_stop_in(rx_stop_in), .rx_break(1'b0), .char_tick(char_tick),
        .tx_take(tx_take), .tx_data_q(tx_data_q), .tx_avail_q(tx_avail_q),
        .tx_par_q(tx_par_q), .word_len_q(word_len_q),
        .stop_half_q(stop_half_q), .stop_two_q(stop_two_q),
        .parity_on_q(parity_on_q), .break_q(break_q), .dlab_q(dlab_q),
        .modem_chg(modem_chg), .osc_off_bit(1'b1), .osc_stop_q(osc_stop_q),
        .irq_q(irq_q), .tx_dma_request_n_q(tx_dma_request_n_q),
        .rx_dma_request_n_q(rx_dma_request_n_q)
    );
    ufc_shift_model i_ufc_shift_model (
        .ref_clk(ref_clk), .rst(rst), .tx_avail_q(tx_avail_q),
        .tx_data_q(tx_data_q), .tx_take(tx_take),
        .last_byte_q(last_byte_q), .n_taken_q(n_taken_q),
        .tick_en(tick_en), .char_tick(char_tick)
    );
    // ------------------------------------------------------------
    // expectations and tasks
    // ------------------------------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] idx(input f, input x5, input x4, input [3:0] k);
        idx = {f, f, x5, x4, k[3] & f, k[2:0]};
    endfunction
    function [7:0] fmt(input [7:0] d);
        fmt = {1'b0, d[7], d[6], d[3], d[2] && d[1:0] != 2'h0,
            d[2] && d[1:0] == 2'h0, d[1:0]};
    endfunction
    task check(input [7:0] seen, input [7:0] exp, input string nm);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task acc(input [2:0] a, input w, input [7:0] d);
        @(posedge ref_clk);
        bus_sel <= 1'b1;
        bus_addr <= a;
        bus_wr <= w;
        bus_rd <= !w;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_sel <= 1'b0;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        #1 rd_v = bus_rdata_q;
    endtask
    task rd(input [2:0] a, input [7:0] exp, input string nm);
        acc(a, 1'b0, 8'h00);
        check(rd_v, exp, nm);
    endtask
    task push(input [7:0] d, input stp, input m);
        @(posedge ref_clk);
        rx_push <= 1'b1;
        rx_data <= d;
        rx_stop_in <= stp;
        modem_chg <= m;
        @(posedge ref_clk);
        rx_push <= 1'b0;
        modem_chg <= 1'b0;
        #1;
    endtask
    task wait_irq(input v);
        c = 0;
        while (irq_q !== v && c < 300) begin
            @(posedge ref_clk);
            #1 c = c + 1;
        end
        check({7'h00, irq_q}, {7'h00, v}, "irq");
        if (irq_q !== v) give_verdict;
    endtask
    task wait_tx(input [7:0] k);
        c = 0;
        while (n_taken_q === k && c < 100) begin
            @(posedge ref_clk);
            #1 c = c + 1;
        end
        if (n_taken_q === k) check(n_taken_q, k + 8'h01, "taken");
        if (n_taken_q === k) give_verdict;
    endtask
    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, bus_sel, bus_wr, bus_rd, rx_push, modem_chg} = 6'h20;
        {tick_en, rx_stop_in, bus_addr, bus_wdata, rx_data} = 21'h0;
        seed = 32'hEAB6;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        #1 check({6'h00, tx_dma_request_n_q, rx_dma_request_n_q}, 8'h03,
            "dma_pins");
        rd(3'h1, 8'h00, "ier");
        rd(3'h2, 8'h01, "ident");
        rd(3'h3, 8'h00, "lcr");
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            b = {1'b0, seed[6], i[1:0], 1'b1, seed[2], i[2:1]};
            wr_then(b);
        end
        acc(3'h3, 1'b1, 8'h03);
        acc(3'h2, 1'b1, 8'h41);
        acc(3'h1, 1'b1, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            q[i] = seed[7:0];
            push(q[i], 1'b1, 1'b0);
        end
        wait_irq(1'b1);
        check({6'h00, tx_dma_request_n_q, rx_dma_request_n_q}, 8'h00,
            "dma_pins");
        rd(3'h2, 8'hC4, "ident");
        rd(3'h0, q[0], "data");
        wait_irq(1'b0);
        tick_en <= 1'b1;
        wait_irq(1'b1);
        check({7'h00, c >= 20}, 8'h01, "timeout_gap");
        rd(3'h2, 8'hCC, "ident");
        tick_en <= 1'b0;
        rd(3'h0, q[1], "data");
        wait_irq(1'b0);
        acc(3'h1, 1'b1, 8'h21);
        rd(3'h2, idx(1'b1, 1'b1, 1'b1, 4'h1), "ident");
        check({7'h00, osc_stop_q}, 8'h01, "osc_stop");
        acc(3'h2, 1'b1, 8'h4B);
        rd(3'h2, idx(1'b1, 1'b0, 1'b1, 4'h1), "ident");
        check({6'h00, tx_dma_request_n_q, rx_dma_request_n_q}, 8'h01,
            "dma_pins");
        acc(3'h1, 1'b1, 8'h22);
        wait_irq(1'b1);
        rd(3'h2, idx(1'b1, 1'b0, 1'b1, 4'h2), "ident");
        wait_irq(1'b0);
        acc(3'h1, 1'b1, 8'h0C);
        push(8'h00, 1'b0, 1'b1);
        wait_irq(1'b1);
        rd(3'h2, 8'hC6, "ident");
        check({7'h00, osc_stop_q}, 8'h00, "osc_stop");
        acc(3'h5, 1'b0, 8'h00);
        rd(3'h2, 8'hC0, "ident");
        acc(3'h6, 1'b0, 8'h00);
        wait_irq(1'b0);
        acc(3'h2, 1'b1, 8'h00);
        acc(3'h1, 1'b1, 8'h20);
        rd(3'h2, idx(1'b0, 1'b0, 1'b1, 4'h1), "ident");
        give_verdict;
    end
    task wr_then(input [7:0] d);
        reg [7:0] k;
        acc(3'h3, 1'b1, d);
        rd(3'h3, d, "lcr");
        check({1'b0, dlab_q, break_q, parity_on_q, stop_two_q, stop_half_q,
            word_len_q}, fmt(d), "format");
        seed = lfsr(seed);
        k = n_taken_q;
        acc(3'h0, 1'b1, seed[15:8]);
        wait_tx(k);
        check(last_byte_q, seed[15:8] & (8'hFF >> (2'h3 - d[1:0])),
            "tx_byte");
    endtask
endmodule // ufc_ctrl_bench
